// ---- hw/banked_general_register_file.sv ----
// banked general register file: four banks of eight nibble registers
// Summary of operation
// - eight nibble registers in the active bank
// - bank n at addresses n*8 to n*8+7
// - nibble accumulator is operand and destination
// - four pairs selectable in active bank
// - primed pairs come from bank bit0 inverted
// - wide accumulator pair is the 8-bit accumulator
// - pointer pairs feed data memory addresses
// - pair increment skips on wrap to zero
// - pair add skips on carry out
// - subtract source and carry into destination
// - table read loads wide accumulator pair
// - decode peripheral window F80 to FFF
// - direct bit access needs enable 0 or bank 15
// - short-form bit access always reaches targets
// - low-nibble-indirect bit access always reaches targets
// - nibble access rules for direct and pointer
// - byte access needs even address or pointer
// - enable clear forces bank zero
// - effective memory bank is enable AND select
`timescale 1ns/10ps
`default_nettype none
module banked_general_register_file (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // bank control
  input wire logic bank_enable_flag,
  input wire logic [1:0] bank_select_field,
  input wire logic memory_bank_enable,
  input wire logic [3:0] memory_bank_select,
  // command from the execution unit, at most one per two cycles
  input wire logic cmdValid,
  input wire gpr_bank_pkg::gpr_cmd_t cmd,
  // peripheral access check request
  input wire gpr_bank_pkg::periph_req_t periphReq,
  // results
  output logic [1:0] active_bank_number,
  output logic [7:0] wide_accumulator_pair,
  output logic [3:0] nibbleResult,
  output gpr_bank_pkg::gpr_flags_t flags,
  output logic flagsValid,
  output logic [7:0] primary_pointer_pair,
  output logic [7:0] aux_pointer_pair,
  output logic [7:0] mixed_aux_pointer_pair,
  output logic [12:0] tableAddr,
  output logic periphInWindow,
  output logic periphAllowed,
  output logic [3:0] effMemBank,
  // program counter for table read address
  input wire logic [12:0] progCounter
);

  // ************************************************************
  // bank selection
  // ************************************************************
  logic [1:0] curBank;   // active bank, combinational
  logic [1:0] primeBank; // sibling bank
  assign curBank = bank_select_field & {2{bank_enable_flag}};
  assign primeBank = {curBank[1], ~curBank[0]};

  // address of a pair or nibble in the register area
  function automatic logic [4:0] reg_addr(input logic [1:0] bank, input logic [2:0] ofs);
    reg_addr = {bank, ofs};
  endfunction

  // ************************************************************
  // state: the current command held for its second cycle
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,  // waiting for a command
    ST_EXEC = 2'b10   // operands read, write back
  } seq_t;
  seq_t state;
  gpr_bank_pkg::gpr_cmd_t held; // command being executed
  logic [1:0] heldBank;         // bank sampled with the command

  // commands are taken one per two cycles because reads are registered
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state <= ST_IDLE;
    else
    begin
      unique case (state)
        ST_IDLE: if (cmdValid) state <= ST_EXEC;
        ST_EXEC: state <= ST_IDLE;
      endcase
    end
  end

  // capture command and bank
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      held <= '0;
      heldBank <= 2'h0;
    end
    else if (state == ST_IDLE && cmdValid)
    begin
      held <= cmd;
      heldBank <= curBank;
    end
  end

  // ************************************************************
  // storage
  // ************************************************************
  logic [4:0] rdAddrA; // accumulator side
  logic [4:0] rdAddrB; // operand side
  logic [7:0] accData;
  logic [7:0] opData;
  logic wrLoEn;
  logic wrHiEn;
  logic [4:0] wrAddr;
  logic [7:0] wrData;
  logic [1:0] opBank;

  assign opBank = cmd.primed ? primeBank : curBank;
  // accumulator reads: pair store/sub read the acc; sub targets the dest
  assign rdAddrA = reg_addr(curBank, gpr_bank_pkg::OFS_WIDE_ACC);
  assign rdAddrB = (cmd.op inside {gpr_bank_pkg::OP_NIB_MOVE, gpr_bank_pkg::OP_NIB_STORE,
                    gpr_bank_pkg::OP_NIB_INC, gpr_bank_pkg::OP_NIB_DEC,
                    gpr_bank_pkg::OP_NIB_CMP})
                   ? reg_addr(curBank, cmd.regSel)
                   : reg_addr(opBank, {cmd.pairSel, 1'b0});

  gpr_nibble_store #(
    .DEPTH(gpr_bank_pkg::NUM_BANKS * gpr_bank_pkg::REGS_PER_BANK)
  ) u_store (
    .ref_clk(ref_clk),
    .srst(srst),
    .wrLoEn(wrLoEn),
    .wrHiEn(wrHiEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddrA(rdAddrA),
    .rdDataA(accData),
    .rdAddrB(rdAddrB),
    .rdDataB(opData)
  );

  // ************************************************************
  // execute
  // ************************************************************
  logic [8:0] sum;       // pair arithmetic with carry
  logic [3:0] nib;       // addressed nibble
  logic [3:0] accNib;    // nibble accumulator
  logic [4:0] heldOpAddr;
  logic [1:0] heldOpBank;
  gpr_bank_pkg::gpr_flags_t next_flags;

  assign heldOpBank = held.primed ? {heldBank[1], ~heldBank[0]} : heldBank;
  assign heldOpAddr = reg_addr(heldOpBank, {held.pairSel, 1'b0});
  assign accNib = accData[3:0];
  assign nib = held.regSel[0] ? opData[7:4] : opData[3:0];

  always_comb
  begin
    sum = 9'h000;
    wrLoEn = 1'b0;
    wrHiEn = 1'b0;
    wrAddr = reg_addr(heldBank, gpr_bank_pkg::OFS_WIDE_ACC);
    wrData = 8'h00;
    next_flags = '0;
    if (state == ST_EXEC)
    begin
      unique case (held.op)
        gpr_bank_pkg::OP_NIB_MOVE:
        begin
          wrLoEn = 1'b1;
          wrData = {4'h0, nib};
        end
        gpr_bank_pkg::OP_NIB_STORE, gpr_bank_pkg::OP_NIB_INC, gpr_bank_pkg::OP_NIB_DEC:
        begin
          wrAddr = reg_addr(heldBank, {held.regSel[2:1], 1'b0});
          wrLoEn = !held.regSel[0];
          wrHiEn = held.regSel[0];
          if (held.op == gpr_bank_pkg::OP_NIB_STORE)
            wrData = {accNib, accNib};
          else if (held.op == gpr_bank_pkg::OP_NIB_INC)
            wrData = {nib + 4'h1, nib + 4'h1};
          else
            wrData = {nib - 4'h1, nib - 4'h1};
        end
        gpr_bank_pkg::OP_NIB_CMP:
          next_flags.equal = (nib == accNib);
        gpr_bank_pkg::OP_PAIR_MOVE, gpr_bank_pkg::OP_TABLE_READ:
        begin
          wrLoEn = 1'b1;
          wrHiEn = 1'b1;
          wrData = (held.op == gpr_bank_pkg::OP_TABLE_READ) ? held.tableData : opData;
        end
        gpr_bank_pkg::OP_PAIR_STORE:
        begin
          wrAddr = heldOpAddr;
          wrLoEn = 1'b1;
          wrHiEn = 1'b1;
          wrData = accData;
        end
        gpr_bank_pkg::OP_INC_SKIP, gpr_bank_pkg::OP_PAIR_DEC:
        begin
          wrAddr = heldOpAddr;
          wrLoEn = 1'b1;
          wrHiEn = 1'b1;
          wrData = (held.op == gpr_bank_pkg::OP_INC_SKIP) ? opData + 8'h01 : opData - 8'h01;
          next_flags.skip = (held.op == gpr_bank_pkg::OP_INC_SKIP)
                            && (wrData == gpr_bank_pkg::PAIR_WRAP);
        end
        gpr_bank_pkg::OP_ADD_SKIP:
        begin
          sum = {1'b0, accData} + {1'b0, opData};
          wrLoEn = 1'b1;
          wrHiEn = 1'b1;
          wrData = sum[7:0];
          next_flags.carry = sum[8];
          next_flags.skip = sum[8];
        end
        gpr_bank_pkg::OP_SUB_CARRY:
        begin
          // destination is the selected pair, source the wide accumulator
          sum = {1'b0, opData} - {1'b0, accData} - {8'h00, held.carryIn};
          wrAddr = heldOpAddr;
          wrLoEn = 1'b1;
          wrHiEn = 1'b1;
          wrData = sum[7:0];
          next_flags.carry = sum[8];
        end
        gpr_bank_pkg::OP_PAIR_CMP:
        begin
          sum = {1'b0, accData} - {1'b0, opData};
          next_flags.carry = sum[8];
          next_flags.equal = (accData == opData);
          next_flags.skip = (accData == opData);
        end
        default: ;
      endcase
    end
  end

  // flag outputs, one cycle pulse on flagsValid
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      flags <= '0;
      flagsValid <= 1'b0;
      nibbleResult <= 4'h0;
    end
    else
    begin
      flagsValid <= (state == ST_EXEC);
      if (state == ST_EXEC)
      begin
        flags <= next_flags;
        nibbleResult <= wrHiEn ? wrData[7:4] : wrData[3:0];
      end
    end
  end

  // ************************************************************
  // shadow copies of bank 0's pairs for outputs
  // ************************************************************
  logic [7:0] shadow [4]; // kept in step with writes to bank 0 (shadowBank stays 0)
  logic [1:0] shadowBank;

  // shadow tracks writes to bank 0 so outputs show bank 0's stored cells
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 4; i++)
        shadow[i] <= 8'h00;
      shadowBank <= 2'h0;
    end
    else if (wrAddr[4:3] == shadowBank && (wrLoEn || wrHiEn))
    begin
      if (wrLoEn)
        shadow[wrAddr[2:1]][3:0] <= wrData[3:0];
      if (wrHiEn)
        shadow[wrAddr[2:1]][7:4] <= wrData[7:4];
    end
  end

  // registered outputs: active bank number and bank 0 pairs
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      active_bank_number <= 2'h0;
      wide_accumulator_pair <= 8'h00;
      primary_pointer_pair <= 8'h00;
      aux_pointer_pair <= 8'h00;
      mixed_aux_pointer_pair <= 8'h00;
      tableAddr <= 13'h0000;
    end
    else
    begin
      active_bank_number <= curBank;
      wide_accumulator_pair <= shadow[gpr_bank_pkg::OFS_WIDE_ACC[2:1]];
      primary_pointer_pair <= shadow[gpr_bank_pkg::OFS_PRIMARY_PTR[2:1]];
      aux_pointer_pair <= shadow[gpr_bank_pkg::OFS_AUX_PTR[2:1]];
      mixed_aux_pointer_pair <= {shadow[gpr_bank_pkg::OFS_AUX_PTR[2:1]][7:4],
                                 shadow[gpr_bank_pkg::OFS_PRIMARY_PTR[2:1]][3:0]};
      tableAddr <= {progCounter[12:8], shadow[gpr_bank_pkg::OFS_AUX_PTR[2:1]]};
    end
  end

  // ************************************************************
  // peripheral window checks
  // ************************************************************
  periph_access_check u_periph (
    .ref_clk(ref_clk),
    .srst(srst),
    .req(periphReq),
    .memory_bank_enable(memory_bank_enable),
    .memory_bank_select(memory_bank_select),
    .inWindow(periphInWindow),
    .allowed(periphAllowed),
    .effMemBank(effMemBank)
  );

endmodule
`default_nettype wire

// ---- hw/gpr_bank_pkg.sv ----
// package: constants, enums and carrier structs for the banked general register file
package gpr_bank_pkg;

  // ************************************************************
  // storage geometry
  // ************************************************************
  localparam int NUM_BANKS = 4;           // register banks
  localparam int REGS_PER_BANK = 8;       // nibble registers per bank
  localparam int NIB_W = 4;               // register width
  localparam logic [3:0] NIB_RESET = 4'h0; // value after reset

  // ************************************************************
  // pair offsets inside a bank (low nibble at the even address)
  // ************************************************************
  localparam logic [2:0] OFS_WIDE_ACC = 3'h0;   // wide accumulator pair
  localparam logic [2:0] OFS_PRIMARY_PTR = 3'h2; // primary pointer pair
  localparam logic [2:0] OFS_AUX_PTR = 3'h4;     // aux pointer pair
  localparam logic [2:0] OFS_SPARE = 3'h6;       // spare general pair
  localparam logic [2:0] OFS_NIB_ACC = 3'h0;     // nibble accumulator

  // ************************************************************
  // data memory windows
  // ************************************************************
  localparam logic [11:0] GPR_ADDR_LAST = 12'h01F;  // end of register area
  localparam logic [11:0] PERIPH_FIRST = 12'hF80;   // peripheral window start
  localparam logic [11:0] PERIPH_LAST = 12'hFFF;    // peripheral window end
  localparam logic [3:0] PERIPH_MEM_BANK = 4'hF;    // bank select reaching peripherals
  localparam logic [7:0] PAIR_WRAP = 8'h00;         // increment wrap value

  // ************************************************************
  // operations
  // ************************************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_NIB_MOVE = 4'h1,  // nibble acc <- reg
    OP_NIB_STORE = 4'h2, // reg <- nibble acc
    OP_NIB_INC = 4'h3,
    OP_NIB_DEC = 4'h4,
    OP_PAIR_MOVE = 4'h5, // wide acc <- pair
    OP_PAIR_STORE = 4'h6, // pair <- wide acc
    OP_INC_SKIP = 4'h7,  // increment_and_skip
    OP_ADD_SKIP = 4'h8,  // add_and_skip
    OP_SUB_CARRY = 4'h9, // subtract_with_carry
    OP_TABLE_READ = 4'hA, // table_read
    OP_PAIR_CMP = 4'hB,  // compare / skip_if_equal
    OP_PAIR_DEC = 4'hC,
    OP_NIB_CMP = 4'hD
  } gpr_op_t;

  // peripheral addressing modes
  typedef enum logic [2:0] {
    AM_BIT_DIRECT = 3'h0,
    AM_BIT_SHORT = 3'h1,
    AM_BIT_LOWIND = 3'h2,
    AM_NIB_DIRECT = 3'h3,
    AM_NIB_POINTER = 3'h4,
    AM_BYTE_DIRECT = 3'h5,
    AM_BYTE_POINTER = 3'h6
  } addr_mode_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    gpr_op_t op;       // operation
    logic [2:0] regSel; // nibble register index
    logic [1:0] pairSel; // pair index (offset/2)
    logic primed;      // use sibling bank
    logic carryIn;     // carry flag for subtract
    logic [7:0] tableData; // program memory byte
  } gpr_cmd_t;

  typedef struct packed {
    logic skip;      // skip next instruction
    logic carry;     // carry or borrow out
    logic equal;     // operands equal
  } gpr_flags_t;

  typedef struct packed {
    addr_mode_t mode;
    logic [11:0] addr;
    logic [3:0] lowPointer;
  } periph_req_t;

endpackage

// ---- hw/gpr_nibble_store.sv ----
// nibble storage for all banks, with two registered pair read ports
`timescale 1ns/10ps
`default_nettype none
module gpr_nibble_store #(
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // write port, two nibbles
  input wire logic wrLoEn,
  input wire logic wrHiEn,
  input wire logic [4:0] wrAddr,
  input wire logic [7:0] wrData,
  // read ports, a pair at even address
  input wire logic [4:0] rdAddrA,
  output logic [7:0] rdDataA,
  input wire logic [4:0] rdAddrB,
  output logic [7:0] rdDataB
);

  // ************************************************************
  // storage cells
  // ************************************************************
  logic [3:0] cells [DEPTH]; // one cell per nibble register

  // one write port serves both views, so nibble and pair alias the same cells
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < DEPTH; i++)
        cells[i] <= gpr_bank_pkg::NIB_RESET;
    end
    else
    begin
      if (wrLoEn)
        cells[wrAddr] <= wrData[3:0];
      if (wrHiEn)
        cells[wrAddr | 5'h01] <= wrData[7:4];
    end
  end

  // registered reads; each port returns the pair at its even base
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rdDataA <= 8'h00;
      rdDataB <= 8'h00;
    end
    else
    begin
      rdDataA <= {cells[rdAddrA | 5'h01], cells[rdAddrA & 5'h1E]};
      rdDataB <= {cells[rdAddrB | 5'h01], cells[rdAddrB & 5'h1E]};
    end
  end

endmodule
`default_nettype wire

// ---- hw/periph_access_check.sv ----
// peripheral window decode and addressing mode checks
`timescale 1ns/10ps
`default_nettype none
module periph_access_check (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // request
  input wire gpr_bank_pkg::periph_req_t req,
  input wire logic memory_bank_enable,
  input wire logic [3:0] memory_bank_select,
  // result
  output logic inWindow,
  output logic allowed,
  output logic [3:0] effMemBank
);

  // ************************************************************
  // decode helper
  // ************************************************************
  function automatic logic in_periph(input logic [11:0] a);
    in_periph = (a >= gpr_bank_pkg::PERIPH_FIRST) && (a <= gpr_bank_pkg::PERIPH_LAST);
  endfunction

  logic bankF;   // enable set and bank 15 selected
  logic direct;  // direct forms: enable clear or bank 15
  logic next_allowed;
  assign bankF = memory_bank_enable && (memory_bank_select == gpr_bank_pkg::PERIPH_MEM_BANK);
  assign direct = !memory_bank_enable || bankF;

  // mode check
  always_comb
  begin
    next_allowed = 1'b0;
    unique case (req.mode)
      gpr_bank_pkg::AM_BIT_DIRECT: next_allowed = direct;
      gpr_bank_pkg::AM_BIT_SHORT: next_allowed = 1'b1;
      gpr_bank_pkg::AM_BIT_LOWIND: next_allowed = 1'b1;
      gpr_bank_pkg::AM_NIB_DIRECT: next_allowed = direct;
      gpr_bank_pkg::AM_NIB_POINTER: next_allowed = bankF;
      gpr_bank_pkg::AM_BYTE_DIRECT: next_allowed = direct && !req.addr[0];
      gpr_bank_pkg::AM_BYTE_POINTER: next_allowed = bankF && !req.lowPointer[0];
      default: next_allowed = 1'b0; // illegal code
    endcase
  end

  // registered results
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      inWindow <= 1'b0;
      allowed <= 1'b0;
      effMemBank <= 4'h0;
    end
    else
    begin
      inWindow <= in_periph(req.addr);
      allowed <= in_periph(req.addr) && next_allowed;
      effMemBank <= memory_bank_select & {4{memory_bank_enable}};
    end
  end

endmodule
`default_nettype wire

// ---- verification/banked_general_register_file_tb.sv ----
// self-checking bench for the banked general register file
`timescale 1ns/10ps
`default_nettype none
module banked_general_register_file_tb;
  // **********
  // stimulus and observed signals
  // **********
  logic ref_clk, srst, bank_enable_flag, memory_bank_enable, cmdValid, flagsValid;
  logic periphInWindow, periphAllowed;
  logic [1:0] bank_select_field, active_bank_number;
  logic [3:0] memory_bank_select, nibbleResult, effMemBank;
  logic [7:0] wide_accumulator_pair, primary_pointer_pair;
  logic [7:0] aux_pointer_pair, mixed_aux_pointer_pair;
  logic [12:0] progCounter, tableAddr;
  gpr_bank_pkg::gpr_cmd_t cmd;
  gpr_bank_pkg::periph_req_t periphReq;
  gpr_bank_pkg::gpr_flags_t flags;
  int bad_count, num_checks;

  banked_general_register_file banked_general_register_file_inst (.ref_clk, .srst,
    .bank_enable_flag, .bank_select_field, .memory_bank_enable, .memory_bank_select,
    .cmdValid, .cmd, .periphReq, .active_bank_number, .wide_accumulator_pair, .nibbleResult,
    .flags, .flagsValid, .primary_pointer_pair, .aux_pointer_pair, .mixed_aux_pointer_pair,
    .tableAddr, .periphInWindow, .periphAllowed, .effMemBank, .progCounter);
  exec_unit_model exec_unit_model_inst (.ref_clk, .cmdValid, .cmd);

  always #5 ref_clk = ~ref_clk; // 100 MHz

  // **********
  // shared tasks
  // **********
  // compare and count; x matches only an expected x
  task automatic check(input logic [12:0] seen, input logic [12:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // wide accumulator from a table byte
  task automatic load(input logic [7:0] v);
    exec_unit_model_inst.issue(gpr_bank_pkg::OP_TABLE_READ, 3'h0, 2'h0, 1'b0, 1'b0, v);
  endtask

  // wide accumulator copied to a pair
  task automatic store(input logic [1:0] ps, input logic pr);
    exec_unit_model_inst.issue(gpr_bank_pkg::OP_PAIR_STORE, 3'h0, ps, pr, 1'b0, 8'h00);
  endtask

  // **********
  // scenarios
  // **********
  // every enable and select combination
  task automatic t_bank();
    for (int i = 0; i < 8; i++)
    begin
      bank_enable_flag = i[2];
      bank_select_field = i[1:0];
      repeat (2) @(posedge ref_clk);
      #1;
      check(13'(active_bank_number), i[2] ? 13'(i[1:0]) : 13'h0000, "bank");
    end
    bank_enable_flag = 1'b0;
    $display("bank select test done");
  endtask

  // pair load, store and increment wrap in bank 0
  task automatic t_pairs();
    load(8'hFF);
    check(13'(wide_accumulator_pair), 13'h00FF, "table load");
    store(2'h1, 1'b0);
    check(13'(primary_pointer_pair), 13'h00FF, "pair store");
    exec_unit_model_inst.issue(gpr_bank_pkg::OP_INC_SKIP, 3'h0, 2'h1, 1'b0, 1'b0, 8'h00);
    check(13'(primary_pointer_pair), 13'h0000, "inc wrap");
    check(13'(flags.skip), 13'h0001, "inc skip");
    $display("pair test done");
  endtask

  // add, subtract, table address, compare, nibble views
  task automatic t_arith();
    load(8'hF0);
    store(2'h3, 1'b0);
    load(8'h20);
    exec_unit_model_inst.issue(gpr_bank_pkg::OP_ADD_SKIP, 3'h0, 2'h3, 1'b0, 1'b0, 8'h00);
    check(13'(wide_accumulator_pair), 13'h0010, "add sum");
    check(13'({flags.carry, flags.skip}), 13'h0003, "add carry skip");
    load(8'h50);
    store(2'h2, 1'b0);
    load(8'h10);
    exec_unit_model_inst.issue(gpr_bank_pkg::OP_SUB_CARRY, 3'h0, 2'h2, 1'b0, 1'b1, 8'h00);
    check(13'(aux_pointer_pair), 13'h003F, "sub result");
    check(13'(flags.carry), 13'h0000, "sub borrow");
    check(13'(mixed_aux_pointer_pair), 13'h0030, "mixed pointer");
    load(8'h3F);
    check(tableAddr, {5'h1A, 8'h3F}, "table address");
    exec_unit_model_inst.issue(gpr_bank_pkg::OP_PAIR_CMP, 3'h0, 2'h2, 1'b0, 1'b0, 8'h00);
    check(13'({flags.equal, flags.skip}), 13'h0003, "compare");
    exec_unit_model_inst.issue(gpr_bank_pkg::OP_NIB_MOVE, 3'h4, 2'h0, 1'b0, 1'b0, 8'h00);
    check(13'(nibbleResult), 13'h000F, "nibble alias");
    $display("arithmetic test done");
  endtask

  // store from bank 1 into its primed pair, seen later from bank 0
  task automatic t_primed();
    bank_enable_flag = 1'b1;
    bank_select_field = 2'h1;
    load(8'hA5);
    store(2'h3, 1'b1);
    bank_enable_flag = 1'b0;
    check(13'(wide_accumulator_pair), 13'h003F, "bank 0 untouched");
    exec_unit_model_inst.issue(gpr_bank_pkg::OP_PAIR_MOVE, 3'h0, 2'h3, 1'b0, 1'b0, 8'h00);
    check(13'(wide_accumulator_pair), 13'h00A5, "primed pair");
    $display("primed pair test done");
  endtask

  // one peripheral request, answered one cycle later
  task automatic pc(input logic [2:0] m, input logic [11:0] a, input logic e,
    input logic [3:0] s, input logic [3:0] lp, input logic w, input logic ok);
    periphReq = '{gpr_bank_pkg::addr_mode_t'(m), a, lp};
    memory_bank_enable = e;
    memory_bank_select = s;
    @(posedge ref_clk);
    #1;
    check(13'(periphInWindow), 13'(w), "window");
    check(13'(effMemBank), e ? 13'(s) : 13'h0000, "mem bank");
    if (w)
      check(13'(periphAllowed), 13'(ok), "allowed");
  endtask

  // every addressing mode; direct bit and pointer byte on both sides of their conditions
  task automatic t_periph();
    pc(3'h0, 12'hF85, 1'b0, 4'h0, 4'h0, 1'b1, 1'b1);
    pc(3'h0, 12'hF85, 1'b1, 4'hE, 4'h0, 1'b1, 1'b0);
    pc(3'h1, 12'hFF0, 1'b1, 4'h3, 4'h0, 1'b1, 1'b1);
    pc(3'h2, 12'hFC4, 1'b1, 4'h2, 4'h0, 1'b1, 1'b1);
    pc(3'h3, 12'hF84, 1'b1, 4'hF, 4'h0, 1'b1, 1'b1);
    pc(3'h4, 12'hF84, 1'b0, 4'h0, 4'h0, 1'b1, 1'b0);
    pc(3'h5, 12'hF83, 1'b0, 4'h0, 4'h0, 1'b1, 1'b0);
    pc(3'h6, 12'hFA6, 1'b1, 4'hF, 4'h3, 1'b1, 1'b0);
    pc(3'h6, 12'hFA6, 1'b1, 4'hF, 4'h2, 1'b1, 1'b1);
    pc(3'h3, 12'hF7F, 1'b0, 4'h0, 4'h0, 1'b0, 1'b0);
    $display("peripheral test done");
  endtask

  // counts, verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // **********
  // main sequence and watchdog
  // **********
  initial
  begin
    ref_clk = 1'b0;
    srst = 1'b1;
    bank_enable_flag = 1'b0;
    bank_select_field = 2'h0;
    memory_bank_enable = 1'b0;
    memory_bank_select = 4'h0;
    periphReq = '0;
    progCounter = 13'h1ABC;
    bad_count = 0;
    num_checks = 0;
    repeat (12) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    t_bank();
    t_pairs();
    t_arith();
    t_primed();
    t_periph();
    final_report();
  end

  // run takes some 140 cycles
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule

bind banked_general_register_file gpr_bank_assertions gpr_bank_assertions_inst (.ref_clk,
  .srst, .bank_enable_flag, .bank_select_field, .memory_bank_enable, .memory_bank_select,
  .cmdValid, .cmd, .periphReq, .active_bank_number, .flags, .flagsValid, .periphInWindow,
  .periphAllowed, .effMemBank);
`default_nettype wire

// ---- verification/exec_unit_model.sv ----
// execution unit model: issues register file commands at the legal spacing
`timescale 1ns/10ps
`default_nettype none
module exec_unit_model (
  // clock
  input wire logic ref_clk,
  // command to the register file
  output var logic cmdValid,
  output var gpr_bank_pkg::gpr_cmd_t cmd
);
  // **********
  // command issue
  // **********
  // idle at start
  initial
  begin
    cmdValid = 1'b0;
    cmd = '0;
  end

  // one command, then idle until its results have landed
  task automatic issue(input gpr_bank_pkg::gpr_op_t op, input logic [2:0] rs,
    input logic [1:0] ps, input logic pr, input logic ci, input logic [7:0] td);
    @(posedge ref_clk);
    #1;
    cmdValid = 1'b1;
    cmd = '{op, rs, ps, pr, ci, td};
    @(posedge ref_clk);
    #1;
    cmdValid = 1'b0; // a request held into the busy cycle would be lost
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- verification/gpr_bank_assertions.sv ----
// concurrent checks on the register file ports
`timescale 1ns/10ps
`default_nettype none
module gpr_bank_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // bank control
  input wire logic bank_enable_flag,
  input wire logic [1:0] bank_select_field,
  input wire logic memory_bank_enable,
  input wire logic [3:0] memory_bank_select,
  // requests
  input wire logic cmdValid,
  input wire gpr_bank_pkg::gpr_cmd_t cmd,
  input wire gpr_bank_pkg::periph_req_t periphReq,
  // results
  input wire logic [1:0] active_bank_number,
  input wire gpr_bank_pkg::gpr_flags_t flags,
  input wire logic flagsValid,
  input wire logic periphInWindow,
  input wire logic periphAllowed,
  input wire logic [3:0] effMemBank
);
  // **********
  // one clock domain, reset quiets every check
  // **********
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  bank_zero_a: assert property (!bank_enable_flag |=> active_bank_number == 2'h0)
    else $error("bank not forced to zero");
  bank_sel_a: assert property (bank_enable_flag |=> active_bank_number == $past(bank_select_field))
    else $error("active bank wrong");
  eff_bank_a: assert property (1'b1 |-> ##1
    effMemBank == ($past(memory_bank_select) & {4{$past(memory_bank_enable)}}))
    else $error("effective memory bank wrong");
  window_a: assert property (1'b1 |-> ##1
    periphInWindow == ($past(periphReq.addr) >= gpr_bank_pkg::PERIPH_FIRST))
    else $error("window decode wrong");
  bit_dir_a: assert property ((periphReq.mode == gpr_bank_pkg::AM_BIT_DIRECT) &&
    memory_bank_enable && (memory_bank_select != 4'hF) |=> !periphAllowed)
    else $error("direct bit wrongly allowed");
  short_bit_a: assert property ((periphReq.mode == gpr_bank_pkg::AM_BIT_SHORT) &&
    (periphReq.addr[11:4] == 8'hFF) |=> periphAllowed)
    else $error("short bit access refused");
  nib_ptr_a: assert property ((periphReq.mode == gpr_bank_pkg::AM_NIB_POINTER) &&
    !(memory_bank_enable && (memory_bank_select == 4'hF)) |=> !periphAllowed)
    else $error("pointer nibble wrongly allowed");
  byte_odd_a: assert property ((periphReq.mode == gpr_bank_pkg::AM_BYTE_DIRECT) &&
    periphReq.addr[0] |=> !periphAllowed)
    else $error("odd byte address allowed");
  cmd_answer_a: assert property (cmdValid &&
    (cmd.op == gpr_bank_pkg::OP_ADD_SKIP) |-> ##[2:3] flagsValid)
    else $error("no flags after add");
  flags_pulse_a: assert property ($rose(flagsValid) |=> !flagsValid)
    else $error("flags valid too long");

  // main scenarios reached
  cover property (flagsValid && flags.skip);
  cover property (periphInWindow && periphAllowed);
  cover property (active_bank_number == 2'h3);
endmodule
`default_nettype wire
